/* File: hdl/t16cc_pkg.sv */
// constants, field layouts and state types of the 16-bit capture/compare timer
// assumes a byte-wide register map reached over a 32-bit apb slave, one word per register
package t16cc_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CAP_HI0 = 8'h0c;
  localparam logic [7:0] ADDR_CAP_LO0 = 8'h10;
  localparam logic [7:0] ADDR_CMP_HI0 = 8'h14;
  localparam logic [7:0] ADDR_CMP_LO0 = 8'h18;
  localparam logic [7:0] ADDR_CAP_HI1 = 8'h1c;
  localparam logic [7:0] ADDR_CAP_LO1 = 8'h20;
  localparam logic [7:0] ADDR_CMP_HI1 = 8'h24;
  localparam logic [7:0] ADDR_CMP_LO1 = 8'h28;
  localparam logic [7:0] ADDR_CNT_HI = 8'h2c;
  localparam logic [7:0] ADDR_CNT_LO = 8'h30;
  localparam logic [7:0] ADDR_ALT_HI = 8'h34;
  localparam logic [7:0] ADDR_ALT_LO = 8'h38;

  // control register one fields
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_OVF_IE = 5;
  localparam int C1_CMP_LVL1 = 2;
  localparam int C1_CAP_EDGE0 = 1;
  localparam int C1_CMP_LVL0 = 0;
  // control register two fields
  localparam int C2_CMP_PEN0 = 7;
  localparam int C2_CMP_PEN1 = 6;
  localparam int C2_CLK_HI = 3;
  localparam int C2_CLK_LO = 2;
  localparam int C2_CAP_EDGE1 = 1;
  localparam int C2_EXT_EDGE = 0;
  // status register fields
  localparam int ST_CAP0 = 7;
  localparam int ST_CMP0 = 6;
  localparam int ST_OVF = 5;
  localparam int ST_CAP1 = 4;
  localparam int ST_CMP1 = 3;

  // clock select codes
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  // prescaler terminal counts, one less than the divide ratio
  localparam logic [2:0] PRESC_END2 = 3'h1;
  localparam logic [2:0] PRESC_END4 = 3'h3;
  localparam logic [2:0] PRESC_END8 = 3'h7;

  // reset and reload values
  localparam logic [15:0] COUNT_RELOAD = 16'hfffc;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // synchronised pins: bit 0 external clock, bits 1..2 capture pins
  localparam int PIN_COUNT = 3;
  localparam int PIN_EXT = 0;
  localparam int PIN_CAP0 = 1;

  // pin synchroniser state
  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] s3;
    logic [PIN_COUNT-1:0] stable;
  } t16cc_sync_t;

  // whole timer state
  typedef struct packed {
    logic [15:0] count;
    logic [2:0] presc;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic ovf_flag;
    logic ovf_arm;
    logic [1:0] cap_flag;
    logic [1:0] cap_arm;
    logic [1:0] cap_block;
    logic [1:0][15:0] cap_val;
    logic [1:0] cmp_flag;
    logic [1:0] cmp_arm;
    logic [1:0] cmp_hold;
    logic [1:0][15:0] cmp_val;
    logic [1:0] cmp_pin;
    logic lo_frozen;
    logic [7:0] lo_latch;
    logic [15:0] snap;
    logic [7:0] rdata;
  } t16cc_state_t;

endpackage

/* File: hdl/t16cc_pin_sync.sv */
// three-stage synchroniser with edge pulses for the timer's pins
// assumes asynchronous pins; an edge counts once stages two and three agree
`timescale 1ns/10ps
module t16cc_pin_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins
  input wire logic [t16cc_pkg::PIN_COUNT-1:0] pin,
  // one-cycle edge pulses on the pclk domain
  output logic [t16cc_pkg::PIN_COUNT-1:0] rise,
  output logic [t16cc_pkg::PIN_COUNT-1:0] fall
);

  t16cc_pkg::t16cc_sync_t st;
  t16cc_pkg::t16cc_sync_t next_st;

  // per pin: a change is accepted only when s2 and s3 agree, filtering one-cycle glitches
  genvar g;
  generate
    for (g = 0; g < t16cc_pkg::PIN_COUNT; g++) begin : g_pin
      assign rise[g] = (st.s2[g] == st.s3[g]) && st.s3[g] && !st.stable[g];
      assign fall[g] = (st.s2[g] == st.s3[g]) && !st.s3[g] && st.stable[g];
    end
  endgenerate

  // shift chain; s1 feeds only s2
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // hold while stages two and three disagree, follow them once they agree
    next_st.stable = (st.stable & (st.s2 ^ st.s3)) | (st.s3 & ~(st.s2 ^ st.s3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

/* File: hdl/t16cc_timer.sv */
// 16-bit free-running timer with two input captures and two output compares
// assumes an apb master on pclk, asynchronous pins, and a cpu interrupt mask level input
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module t16cc_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side levels
  input wire logic cpu_irq_mask,
  input wire logic halt_mode,
  output logic timer_irq,
  // pins
  input wire logic ext_count_input,
  input wire logic [1:0] capture_pin,
  output logic [1:0] compare_pin,
  output logic [1:0] compare_pin_oe
);

  t16cc_pkg::t16cc_state_t st;
  t16cc_pkg::t16cc_state_t next_st;

  logic [t16cc_pkg::PIN_COUNT-1:0] pin_rise;
  logic [t16cc_pkg::PIN_COUNT-1:0] pin_fall;
  logic [1:0] clk_sel;
  logic [2:0] presc_end;
  logic tick;
  logic [15:0] count_inc;
  logic [1:0] cap_edge_sel;
  logic [1:0] cap_event;
  logic [1:0] cmp_lvl;
  logic [1:0] cmp_pen;
  logic [1:0] cmp_match;
  logic setup;
  logic acc_rd;
  logic acc_wr;
  logic mapped;
  logic [7:0] rd_mux;

  // capture pins are always watched, whatever the port direction elsewhere
  t16cc_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({capture_pin, ext_count_input}),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // control fields
  assign clk_sel = {st.ctrl2[t16cc_pkg::C2_CLK_HI], st.ctrl2[t16cc_pkg::C2_CLK_LO]};
  assign cap_edge_sel = {st.ctrl2[t16cc_pkg::C2_CAP_EDGE1], st.ctrl1[t16cc_pkg::C1_CAP_EDGE0]};
  assign cmp_lvl = {st.ctrl1[t16cc_pkg::C1_CMP_LVL1], st.ctrl1[t16cc_pkg::C1_CMP_LVL0]};
  assign cmp_pen = {st.ctrl2[t16cc_pkg::C2_CMP_PEN1], st.ctrl2[t16cc_pkg::C2_CMP_PEN0]};

  // prescaler terminal count for the chosen internal divide
  always_comb begin
    if (clk_sel == t16cc_pkg::CLK_DIV2) begin
      presc_end = t16cc_pkg::PRESC_END2;
    end else if (clk_sel == t16cc_pkg::CLK_DIV8) begin
      presc_end = t16cc_pkg::PRESC_END8;
    end else begin
      presc_end = t16cc_pkg::PRESC_END4;
    end
  end

  // timer tick: internal divide or a synchronised external edge; halt stops both
  always_comb begin
    if (halt_mode) begin
      tick = 1'b0;
    end else if (clk_sel == t16cc_pkg::CLK_EXT) begin
      // edge already resampled onto pclk, so the count never sees the raw pin
      tick = st.ctrl2[t16cc_pkg::C2_EXT_EDGE] ? pin_rise[t16cc_pkg::PIN_EXT]
                                               : pin_fall[t16cc_pkg::PIN_EXT];
    end else begin
      tick = (st.presc == presc_end);
    end
  end

  assign count_inc = st.count + 16'h0001;

  // capture events per channel with polarity select
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      assign cap_event[g] = cap_edge_sel[g] ? pin_rise[t16cc_pkg::PIN_CAP0 + g]
                                             : pin_fall[t16cc_pkg::PIN_CAP0 + g];
      // divide by two matches the new count; slower clocks match one count later
      assign cmp_match[g] = tick && !st.cmp_hold[g] &&
                            ((clk_sel == t16cc_pkg::CLK_DIV2) ? (count_inc == st.cmp_val[g])
                                                              : (st.count == st.cmp_val[g]));
    end
  endgenerate

  // apb phases
  assign setup = psel && !penable;
  assign acc_rd = psel && penable && !pwrite;
  assign acc_wr = psel && penable && pwrite && pstrb[0];

  // read mux and address map; unmapped addresses answer with an error
  always_comb begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    if (paddr == t16cc_pkg::ADDR_CTRL_ONE) begin
      rd_mux = st.ctrl1;
    end else if (paddr == t16cc_pkg::ADDR_CTRL_TWO) begin
      rd_mux = st.ctrl2;
    end else if (paddr == t16cc_pkg::ADDR_STATUS) begin
      rd_mux[t16cc_pkg::ST_CAP0] = st.cap_flag[0];
      rd_mux[t16cc_pkg::ST_CMP0] = st.cmp_flag[0];
      rd_mux[t16cc_pkg::ST_OVF] = st.ovf_flag;
      rd_mux[t16cc_pkg::ST_CAP1] = st.cap_flag[1];
      rd_mux[t16cc_pkg::ST_CMP1] = st.cmp_flag[1];
    end else if (paddr == t16cc_pkg::ADDR_CAP_HI0) begin
      rd_mux = st.cap_val[0][15:8];
    end else if (paddr == t16cc_pkg::ADDR_CAP_LO0) begin
      rd_mux = st.cap_val[0][7:0];
    end else if (paddr == t16cc_pkg::ADDR_CMP_HI0) begin
      rd_mux = st.cmp_val[0][15:8];
    end else if (paddr == t16cc_pkg::ADDR_CMP_LO0) begin
      rd_mux = st.cmp_val[0][7:0];
    end else if (paddr == t16cc_pkg::ADDR_CAP_HI1) begin
      rd_mux = st.cap_val[1][15:8];
    end else if (paddr == t16cc_pkg::ADDR_CAP_LO1) begin
      rd_mux = st.cap_val[1][7:0];
    end else if (paddr == t16cc_pkg::ADDR_CMP_HI1) begin
      rd_mux = st.cmp_val[1][15:8];
    end else if (paddr == t16cc_pkg::ADDR_CMP_LO1) begin
      rd_mux = st.cmp_val[1][7:0];
    end else if (paddr == t16cc_pkg::ADDR_CNT_HI || paddr == t16cc_pkg::ADDR_ALT_HI) begin
      rd_mux = st.count[15:8];
    end else if (paddr == t16cc_pkg::ADDR_CNT_LO || paddr == t16cc_pkg::ADDR_ALT_LO) begin
      rd_mux = st.lo_frozen ? st.lo_latch : st.count[7:0];
    end else begin
      mapped = 1'b0;
    end
  end

  // next state: bus side effects first, hardware sets last so a set beats a clear
  always_comb begin
    next_st = st;
    // prescaler runs whenever not halted; the external clock select holds it at zero
    if (!halt_mode) begin
      next_st.presc = (tick || clk_sel == t16cc_pkg::CLK_EXT) ? 3'h0 : st.presc + 3'h1;
    end
    if (tick) begin
      next_st.count = count_inc;
    end

    // read data is sampled in the setup cycle, with a snapshot of the whole count
    if (setup) begin
      next_st.rdata = mapped ? rd_mux : 8'h00;
      next_st.snap = st.count;
    end

    // status read arms only the flags its setup-cycle image showed set;
    // a flag rising during the access is not armed, so it cannot be cleared unseen
    if (acc_rd && paddr == t16cc_pkg::ADDR_STATUS) begin
      next_st.ovf_arm = st.ovf_arm | st.rdata[t16cc_pkg::ST_OVF];
      next_st.cap_arm = st.cap_arm |
                        {st.rdata[t16cc_pkg::ST_CAP1], st.rdata[t16cc_pkg::ST_CAP0]};
      next_st.cmp_arm = st.cmp_arm |
                        {st.rdata[t16cc_pkg::ST_CMP1], st.rdata[t16cc_pkg::ST_CMP0]};
    end

    // counter bytes: the high read freezes the low byte unless already frozen
    if (acc_rd && (paddr == t16cc_pkg::ADDR_CNT_HI || paddr == t16cc_pkg::ADDR_ALT_HI)) begin
      if (!st.lo_frozen) begin
        next_st.lo_frozen = 1'b1;
        next_st.lo_latch = st.snap[7:0];
      end
    end
    if (acc_rd && (paddr == t16cc_pkg::ADDR_CNT_LO || paddr == t16cc_pkg::ADDR_ALT_LO)) begin
      next_st.lo_frozen = 1'b0;
    end
    if (acc_wr && (paddr == t16cc_pkg::ADDR_CNT_LO || paddr == t16cc_pkg::ADDR_ALT_LO)) begin
      next_st.count = t16cc_pkg::COUNT_RELOAD;
      next_st.presc = 3'h0;
    end
    // only the main low byte completes an overflow clear; the alternate one never does
    if ((acc_rd || acc_wr) && paddr == t16cc_pkg::ADDR_CNT_LO && st.ovf_arm) begin
      next_st.ovf_flag = 1'b0;
      next_st.ovf_arm = 1'b0;
    end

    // control writes
    if (acc_wr && paddr == t16cc_pkg::ADDR_CTRL_ONE) begin
      next_st.ctrl1 = pwdata[7:0];
    end
    if (acc_wr && paddr == t16cc_pkg::ADDR_CTRL_TWO) begin
      next_st.ctrl2 = pwdata[7:0];
    end

    // capture channel 0 byte accesses
    if (acc_rd && paddr == t16cc_pkg::ADDR_CAP_HI0) begin
      next_st.cap_block[0] = 1'b1;
    end
    if (acc_rd && paddr == t16cc_pkg::ADDR_CAP_LO0) begin
      next_st.cap_block[0] = 1'b0;
    end
    if ((acc_rd || acc_wr) && paddr == t16cc_pkg::ADDR_CAP_LO0 && st.cap_arm[0]) begin
      next_st.cap_flag[0] = 1'b0;
      next_st.cap_arm[0] = 1'b0;
    end
    // capture channel 1 byte accesses
    if (acc_rd && paddr == t16cc_pkg::ADDR_CAP_HI1) begin
      next_st.cap_block[1] = 1'b1;
    end
    if (acc_rd && paddr == t16cc_pkg::ADDR_CAP_LO1) begin
      next_st.cap_block[1] = 1'b0;
    end
    if ((acc_rd || acc_wr) && paddr == t16cc_pkg::ADDR_CAP_LO1 && st.cap_arm[1]) begin
      next_st.cap_flag[1] = 1'b0;
      next_st.cap_arm[1] = 1'b0;
    end

    // compare channel 0: high write holds compares off until the low write
    if (acc_wr && paddr == t16cc_pkg::ADDR_CMP_HI0) begin
      next_st.cmp_val[0][15:8] = pwdata[7:0];
      next_st.cmp_hold[0] = 1'b1;
    end
    if (acc_wr && paddr == t16cc_pkg::ADDR_CMP_LO0) begin
      next_st.cmp_val[0][7:0] = pwdata[7:0];
      next_st.cmp_hold[0] = 1'b0;
    end
    if ((acc_rd || acc_wr) && paddr == t16cc_pkg::ADDR_CMP_LO0 && st.cmp_arm[0]) begin
      next_st.cmp_flag[0] = 1'b0;
      next_st.cmp_arm[0] = 1'b0;
    end
    // compare channel 1
    if (acc_wr && paddr == t16cc_pkg::ADDR_CMP_HI1) begin
      next_st.cmp_val[1][15:8] = pwdata[7:0];
      next_st.cmp_hold[1] = 1'b1;
    end
    if (acc_wr && paddr == t16cc_pkg::ADDR_CMP_LO1) begin
      next_st.cmp_val[1][7:0] = pwdata[7:0];
      next_st.cmp_hold[1] = 1'b0;
    end
    if ((acc_rd || acc_wr) && paddr == t16cc_pkg::ADDR_CMP_LO1 && st.cmp_arm[1]) begin
      next_st.cmp_flag[1] = 1'b0;
      next_st.cmp_arm[1] = 1'b0;
    end

    // hardware sets, applied last so they win over any clear in the same cycle
    if (tick && st.count == t16cc_pkg::COUNT_MAX) begin
      next_st.ovf_flag = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      // a blocked channel neither loads nor flags, so the pair being read stays coherent
      if (cap_event[i] && !st.cap_block[i]) begin
        next_st.cap_val[i] = st.count;
        next_st.cap_flag[i] = 1'b1;
      end
      if (cmp_match[i]) begin
        next_st.cmp_flag[i] = 1'b1;
        if (cmp_pen[i]) begin
          next_st.cmp_pin[i] = cmp_lvl[i];
        end
      end
    end
  end

  // one register for the whole state; compares and the counter have their own reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.count <= t16cc_pkg::COUNT_RELOAD;
      st.ctrl1 <= t16cc_pkg::CTRL_RESET;
      st.ctrl2 <= t16cc_pkg::CTRL_RESET;
      st.cmp_val[0] <= t16cc_pkg::CMP_RESET;
      st.cmp_val[1] <= t16cc_pkg::CMP_RESET;
      st.cmp_pin <= 2'h0;
    end else begin
      st <= next_st;
    end
  end

  // one merged request line; each source gated by its enable and by the cpu mask
  assign timer_irq = !cpu_irq_mask &&
                     ((st.ovf_flag && st.ctrl1[t16cc_pkg::C1_OVF_IE]) ||
                      ((|st.cap_flag) && st.ctrl1[t16cc_pkg::C1_CAP_IE]) ||
                      ((|st.cmp_flag) && st.ctrl1[t16cc_pkg::C1_CMP_IE]));

  // pins: without the pin enable the pin is left to general i/o
  assign compare_pin = st.cmp_pin;
  assign compare_pin_oe = cmp_pen;

  // zero-wait slave: data was registered in the setup cycle
  assign prdata = {24'h000000, st.rdata};
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

endmodule

/* File: verif/t16cc_sva.sv */
// port-level checker for the capture/compare timer
// assumes it is bound to t16cc_timer and sees only that module's ports
`timescale 1ns/10ps
module t16cc_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // cpu side and pins
  input wire logic cpu_irq_mask,
  input wire logic halt_mode,
  input wire logic timer_irq,
  input wire logic ext_count_input,
  input wire logic [1:0] capture_pin,
  input wire logic [1:0] compare_pin,
  input wire logic [1:0] compare_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a masked cpu must never see the request line
  property p_mask_quiet;
    cpu_irq_mask |-> !timer_irq;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet)
    else $error("timer irq high while masked");
  // flags are sticky, so the line only drops on a mask or a register access
  property p_irq_fall;
    $fell(timer_irq) |-> $rose(cpu_irq_mask) || $past(psel && penable);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("timer irq dropped without cause");
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("slave error outside access phase");
  property p_err_data;
    psel && penable && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data)
    else $error("error response carries data");
  property p_rdata_hi;
    psel && penable && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi)
    else $error("upper read data not zero");
  property p_ready;
    psel |-> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready low while selected");
  // the pin enables only move after a committed write
  property p_oe_hold;
    !(psel && penable && pwrite) |=> $stable(compare_pin_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("pin enable changed without write");
  // no timer ticks while halted, so no compare can move the pins
  property p_pin_quiet;
    halt_mode && $past(halt_mode) |-> $stable(compare_pin);
  endproperty
  a_pin_quiet: assert property (p_pin_quiet)
    else $error("compare pin moved while halted");
  property p_pin_reset;
    disable iff (1'b0)
    !presetn |-> compare_pin == 2'h0 && compare_pin_oe == 2'h0 && !timer_irq;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("outputs not quiet in reset");

  c_irq: cover property (timer_irq);
  c_err: cover property (pslverr);
  c_pin: cover property ($rose(compare_pin[0]));
endmodule

/* File: verif/t16cc_pin_model.sv */
// far-side model: external count clock and capture pin drivers
// assumes the bench asks for clock bursts and capture levels on pclk edges
`timescale 1ns/10ps
module t16cc_pin_model (
  // clock
  input wire logic pclk,
  // requests from the bench
  input wire logic ext_run,
  input wire logic [1:0] cap_lvl,
  // pins toward the timer
  output logic ext_count_input = 1'b0,
  output logic [1:0] capture_pin = 2'h0
);
  logic [1:0] phase = 2'h0;

  // clock toggles every fourth edge and stands still between bursts
  always @(posedge pclk) begin
    capture_pin <= cap_lvl;
    if (ext_run) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) ext_count_input <= !ext_count_input;
    end else begin
      phase <= 2'h0;
    end
  end
endmodule

/* File: verif/tb.sv */
// self-checking bench for the capture/compare timer
// assumes zero-wait apb answers and a halted counter between scenarios
`timescale 1ns/10ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, timer_irq;
  logic cpu_irq_mask = 1'b1;
  logic halt_mode = 1'b1;
  logic ext_run = 1'b0;
  logic [1:0] cap_lvl = 2'h0;
  logic ext_pin;
  logic [1:0] cap_pin, cmp_pin, cmp_oe;
  int errors = 0;
  int n_checks = 0;

  initial forever #5 pclk = ~pclk;

  t16cc_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask),
    .halt_mode(halt_mode), .timer_irq(timer_irq), .ext_count_input(ext_pin),
    .capture_pin(cap_pin), .compare_pin(cmp_pin), .compare_pin_oe(cmp_oe));
  t16cc_pin_model u_pins (.pclk(pclk), .ext_run(ext_run), .cap_lvl(cap_lvl),
    .ext_count_input(ext_pin), .capture_pin(cap_pin));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; the wait on ready is bounded
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      stop_test();
    end
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic e;
    apb(1'b0, a, 8'h00, q, e);
    chk($sformatf("reg %h", a), {24'h0, q}, {24'h0, exp});
  endtask

  // lets the counter run for exactly n edges, then halts it again
  task automatic run(input int n);
    halt_mode <= 1'b0;
    repeat (n) @(posedge pclk);
    halt_mode <= 1'b1;
  endtask

  // reset values; high byte of each entry is the address, low byte the value
  task automatic t_reset;
    logic [15:0] tbl [10] = '{16'h0000, 16'h0400, 16'h0800, 16'h1480, 16'h1800,
                              16'h2480, 16'h2800, 16'h2cff, 16'h30fc, 16'h38fc};
    logic [7:0] q;
    logic e;
    chk("pins", {cmp_pin, cmp_oe}, 32'h0);
    foreach (tbl[i]) rd(tbl[i][15:8], tbl[i][7:0]);
    apb(1'b0, 8'h3c, 8'h00, q, e);
    chk("unmapped", {e, q}, 32'h100);
    $display("test reset done");
  endtask

  task automatic t_count;
    wr(8'h04, 8'h04);
    wr(8'h00, 8'h20);
    wr(8'h30, 8'h00);
    rd(8'h2c, 8'hff);
    run(8);
    rd(8'h2c, 8'h00);
    rd(8'h30, 8'hfc);
    rd(8'h30, 8'h00);
    rd(8'h08, 8'h20);
    chk("irq masked", timer_irq, 1'b0);
    cpu_irq_mask <= 1'b0;
    @(posedge pclk);
    chk("irq open", timer_irq, 1'b1);
    rd(8'h38, 8'h00);
    rd(8'h08, 8'h20);
    rd(8'h30, 8'h00);
    rd(8'h08, 8'h00);
    chk("irq cleared", timer_irq, 1'b0);
    cpu_irq_mask <= 1'b1;
    $display("test count done");
  endtask

  // seven pin toggles per burst: four on the selected edge, three on the other
  task automatic t_ext;
    for (int m = 0; m < 2; m++) begin
      wr(8'h04, m ? 8'h0c : 8'h0d);
      wr(8'h30, 8'h00);
      halt_mode <= 1'b0;
      ext_run <= 1'b1;
      repeat (30) @(posedge pclk);
      ext_run <= 1'b0;
      repeat (10) @(posedge pclk);
      halt_mode <= 1'b1;
      rd(8'h2c, 8'h00);
      rd(8'h30, 8'h00);
      rd(8'h08, 8'h20);
      rd(8'h30, 8'h00);
    end
    $display("test external clock done");
  endtask

  task automatic t_cap;
    wr(8'h00, 8'h82);
    wr(8'h30, 8'h00);
    cap_lvl <= 2'h1;
    repeat (8) @(posedge pclk);
    cpu_irq_mask <= 1'b0;
    @(posedge pclk);
    chk("irq capture", timer_irq, 1'b1);
    cpu_irq_mask <= 1'b1;
    rd(8'h08, 8'h80);
    rd(8'h0c, 8'hff);
    rd(8'h10, 8'hfc);
    rd(8'h08, 8'h00);
    rd(8'h0c, 8'hff);
    cap_lvl <= 2'h0;
    repeat (8) @(posedge pclk);
    cap_lvl <= 2'h1;
    repeat (8) @(posedge pclk);
    rd(8'h08, 8'h00);
    rd(8'h10, 8'hfc);
    cap_lvl <= 2'h0;
    repeat (8) @(posedge pclk);
    rd(8'h08, 8'h00);
    cap_lvl <= 2'h1;
    repeat (8) @(posedge pclk);
    rd(8'h08, 8'h80);
    rd(8'h10, 8'hfc);
    rd(8'h08, 8'h00);
    $display("test capture done");
  endtask

  task automatic t_cmp;
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h84);
    wr(8'h14, 8'hff);
    wr(8'h18, 8'hfe);
    wr(8'h30, 8'h00);
    run(8);
    chk("pin set", {cmp_pin, cmp_oe}, 32'h5);
    rd(8'h08, 8'h60);
    rd(8'h18, 8'hfe);
    rd(8'h08, 8'h20);
    rd(8'h30, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h14, 8'hff);
    wr(8'h30, 8'h00);
    run(8);
    rd(8'h08, 8'h20);
    chk("pin held", cmp_pin, 2'h1);
    wr(8'h18, 8'hfe);
    wr(8'h30, 8'h00);
    run(8);
    rd(8'h08, 8'h60);
    chk("pin level", cmp_pin, 2'h0);
    $display("test compare done");
  endtask

  // divide by four flags one count late; divide by eight paces the count
  task automatic t_div;
    rd(8'h18, 8'hfe);
    wr(8'h00, 8'h44);
    wr(8'h04, 8'h40);
    wr(8'h24, 8'hff);
    wr(8'h28, 8'hfe);
    wr(8'h30, 8'h00);
    run(8);
    rd(8'h08, 8'h00);
    run(4);
    rd(8'h08, 8'h48);
    chk("pin div4", {cmp_pin, cmp_oe}, 32'ha);
    cpu_irq_mask <= 1'b0;
    @(posedge pclk);
    chk("irq compare", timer_irq, 1'b1);
    cpu_irq_mask <= 1'b1;
    wr(8'h04, 8'h08);
    wr(8'h30, 8'h00);
    run(8);
    rd(8'h34, 8'hff);
    rd(8'h38, 8'hfd);
    $display("test divider done");
  endtask

  initial begin
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_count();
    t_ext();
    t_cap();
    t_cmp();
    t_div();
    stop_test();
  end
endmodule

bind t16cc_timer t16cc_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask),
  .halt_mode(halt_mode), .timer_irq(timer_irq), .ext_count_input(ext_count_input),
  .capture_pin(capture_pin), .compare_pin(compare_pin), .compare_pin_oe(compare_pin_oe));
